// ---- core/citu_device.sv ----
// CPU end of the interrupt and trap unit: enables, priority, response modes.
// Assumes the core pulses boundary_i at every instruction boundary, and after
// each iteration of block instructions, and pulses one instruction event at a time.
`default_nettype none

// Overview of operation
// - One edge NMI input, four low maskable lines.
// - Maskable taken only if line and global enabled.
// - Fixed priority, line 0 highest, line 3 lowest.
// - Peripheral holds its request until acknowledged.
// - No maskable acceptance during EI and next instruction.
// - Accept only at boundaries, including block iterations.
// - Four response modes chosen by mode instruction.
// - Global enable zero blocks every maskable request.
// - NMI: push, save global, clear, fetch 0x66.
// - NMI falling edge is latched and serviced.
// - Return-from-NMI restores global from saved flag.
// - Reset, trap, maskable acceptance clear both flags.
// - EI sets bits and global; DI clears selected.
// - Page/refresh load copies saved flag to PN.
// - Reset clears page and extension registers.
// - Line enables in D3-D0, upper bits read zero.
// - Base bits D7-D1 give A15-A9, bit0 zero.
// - Mode 0 vector on D15-D8 runs as opcode.
// - Undefined mode 0 opcode takes the trap.
// - Mode 1 ignores data, pushes, restarts at 0x38.
// - Mode 2 table address extension, page, vector, even.
// - Mode 3 takes 16-bit vector, pushes PC.
module citu_device (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  citu_if.dev                      link,
  input  wire logic                boundary_i,
  input  wire logic                ei_i,
  input  wire logic                di_i,
  input  wire logic                di_global_i,
  input  wire logic [3:0]          line_sel_i,
  input  wire logic                im_i,
  input  wire citu_pkg::citu_mode_e im_mode_i,
  input  wire logic                return_from_nonmaskable_i,
  input  wire logic                ld_pn_i,
  input  wire logic                trap_i,
  input  wire logic                page_wr_i,
  input  wire logic [7:0]          page_data_i,
  input  wire logic                ext_wr_i,
  input  wire logic [15:0]         ext_data_i,
  input  wire logic                io_wr_i,
  input  wire logic                io_rd_i,
  input  wire logic [7:0]          io_addr_i,
  input  wire logic [7:0]          io_wdata_i,
  output logic      [7:0]          io_rdata_o,
  output logic                     svc_valid_o,
  output citu_pkg::citu_svc_e      svc_kind_o,
  output logic                     svc_push_o,
  output logic      [31:0]         svc_addr_o,
  output logic      [7:0]          svc_opcode_o,
  output logic                     parity_overflow_flag_o,
  output logic                     global_mask_enable_o,
  output logic                     saved_mask_enable_o,
  output logic                     busy_o
);
  import citu_pkg::*;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic        nmi_level;
  logic        nmi_prev;
  logic        nmi_pend;
  logic        nmi_fall;
  logic [3:0]  req_level_n;
  logic [3:0]  line_enable_bits;
  logic [6:0]  vector_base_bits;
  logic [7:0]  vector_page;
  logic [15:0] vector_page_extension;
  citu_mode_e  response_mode_select;
  logic        global_mask_enable;
  logic        saved_mask_enable;
  logic        ei_shadow;
  citu_state_e state;
  logic [1:0]  cur_line;
  logic [3:0]  live_req;
  logic        mask_open;
  logic        take_nmi;
  logic        take_int;
  logic [1:0]  next_line;

  // ---------------------------------------------------------------------
  // Pin filters
  // ---------------------------------------------------------------------
  citu_sync #(.W(1), .RST_VAL(1'b1)) u_nmi_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .pin_i   (link.nmi_n),
    .level_o (nmi_level)
  );

  citu_sync #(.W(4), .RST_VAL(4'hF)) u_req_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .pin_i   (link.maskable_request_n),
    .level_o (req_level_n)
  );

  // ---------------------------------------------------------------------
  // NMI edge latch
  // ---------------------------------------------------------------------
  assign nmi_fall = nmi_prev & ~nmi_level;

  // A new edge in the cycle the old one is serviced stays pending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_prev <= 1'b1;
      nmi_pend <= 1'b0;
    end else if (ce_i) begin
      nmi_prev <= nmi_level;
      nmi_pend <= nmi_fall | (nmi_pend & ~take_nmi);
    end
  end

  // ---------------------------------------------------------------------
  // Acceptance: requests are looked at only on a boundary while idle
  // ---------------------------------------------------------------------
  assign live_req  = ~req_level_n & line_enable_bits;
  assign mask_open = global_mask_enable & ~ei_shadow;
  assign take_nmi  = boundary_i & (state == CITU_ST_IDLE) & nmi_pend;
  assign take_int  = boundary_i & (state == CITU_ST_IDLE) & ~nmi_pend
                   & mask_open & (|live_req);

  // Lowest numbered live line wins
  always_comb begin
    next_line = 2'd0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (live_req[i]) begin
        next_line = 2'(i);
      end
    end
  end

  // EI blocks its own boundary; the following instruction then completes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ei_shadow <= 1'b0;
    end else if (ce_i) begin
      if (ei_i) begin
        ei_shadow <= 1'b1;
      end else if (boundary_i) begin
        ei_shadow <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Enable flags; trap outranks every other update
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_mask_enable <= 1'b0;
      saved_mask_enable  <= 1'b0;
    end else if (ce_i) begin
      if (trap_i || take_int) begin
        global_mask_enable <= 1'b0;
        saved_mask_enable  <= 1'b0;
      end else if (take_nmi) begin
        saved_mask_enable  <= global_mask_enable;
        global_mask_enable <= 1'b0;
      end else if (return_from_nonmaskable_i) begin
        global_mask_enable <= saved_mask_enable;
      end else if (ei_i) begin
        global_mask_enable <= 1'b1;
      end else if (di_i && di_global_i) begin
        global_mask_enable <= 1'b0;
      end
    end
  end

  // Flag copy for the accumulator load; enables stay as they are
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      parity_overflow_flag_o <= 1'b0;
    end else if (ce_i && ld_pn_i) begin
      parity_overflow_flag_o <= saved_mask_enable;
    end
  end

  // ---------------------------------------------------------------------
  // Line enables, vector base, page, extension and mode
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_enable_bits <= LINE_ENABLE_RST;
    end else if (ce_i) begin
      if (io_wr_i && io_addr_i == LINE_ENABLE_OFS) begin
        line_enable_bits <= io_wdata_i[3:0];
      end else if (ei_i) begin
        line_enable_bits <= line_enable_bits | line_sel_i;
      end else if (di_i) begin
        line_enable_bits <= line_enable_bits & ~line_sel_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_base_bits <= VECTOR_BASE_RST;
    end else if (ce_i && io_wr_i && io_addr_i == VECTOR_BASE_OFS) begin
      vector_base_bits <= io_wdata_i[7:VECTOR_BASE_LSB];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vector_page           <= PAGE_RST;
      vector_page_extension <= EXTENSION_RST;
    end else if (ce_i) begin
      if (page_wr_i) begin
        vector_page <= page_data_i;
      end
      if (ext_wr_i) begin
        vector_page_extension <= ext_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      response_mode_select <= CITU_MODE_OPCODE;
    end else if (ce_i && im_i) begin
      response_mode_select <= im_mode_i;
    end
  end

  // Read port; unmapped offsets and reserved bits read as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (ce_i && io_rd_i) begin
      unique case (io_addr_i)
        LINE_ENABLE_OFS: io_rdata_o <= {4'h0, line_enable_bits};
        VECTOR_BASE_OFS: io_rdata_o <= {vector_base_bits, 1'b0};
        default:         io_rdata_o <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Acknowledge transaction: two cycles, vector sampled at the end
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= CITU_ST_IDLE;
      cur_line <= 2'd0;
    end else if (ce_i) begin
      unique case (state)
        CITU_ST_IDLE: begin
          if (take_int) begin
            state    <= CITU_ST_ACK;
            cur_line <= next_line;
          end
        end
        CITU_ST_ACK:    state <= CITU_ST_SAMPLE;
        CITU_ST_SAMPLE: state <= CITU_ST_IDLE;
        default:        state <= CITU_ST_IDLE;
      endcase
    end
  end

  assign link.ack      = (state != CITU_ST_IDLE);
  assign link.ack_line = cur_line;
  assign busy_o        = (state != CITU_ST_IDLE);

  // ---------------------------------------------------------------------
  // Service report to the core, one pulse per accepted event
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svc_valid_o  <= 1'b0;
      svc_kind_o   <= CITU_SVC_NMI;
      svc_push_o   <= 1'b0;
      svc_addr_o   <= 32'h0000_0000;
      svc_opcode_o <= 8'h00;
    end else if (ce_i) begin
      svc_valid_o <= take_nmi || (state == CITU_ST_SAMPLE);
      if (take_nmi) begin
        svc_kind_o <= CITU_SVC_NMI;
        svc_push_o <= 1'b1;
        svc_addr_o <= NMI_ADDR;
      end else if (state == CITU_ST_SAMPLE && cur_line != 2'd0) begin
        // Lines 1-3 go through the assigned table below the base bits
        svc_kind_o <= CITU_SVC_ASSIGNED;
        svc_push_o <= 1'b1;
        svc_addr_o <= {vector_page_extension, vector_base_bits, 5'h00, cur_line, 2'b00};
      end else if (state == CITU_ST_SAMPLE) begin
        unique case (response_mode_select)
          CITU_MODE_OPCODE: begin
            // The core decodes it; an undefined one comes back as trap_i
            svc_kind_o   <= CITU_SVC_OPCODE;
            svc_push_o   <= 1'b0;
            svc_opcode_o <= link.vec_data[15:8];
            svc_addr_o   <= 32'h0000_0000;
          end
          CITU_MODE_RESTART: begin
            svc_kind_o <= CITU_SVC_RESTART;
            svc_push_o <= 1'b1;
            svc_addr_o <= RESTART_ADDR;
          end
          CITU_MODE_TABLE8: begin
            svc_kind_o <= CITU_SVC_TABLE8;
            svc_push_o <= 1'b1;
            svc_addr_o <= {vector_page_extension, vector_page, link.vec_data[15:9], 1'b0};
          end
          CITU_MODE_VEC16: begin
            svc_kind_o <= CITU_SVC_VEC16;
            svc_push_o <= 1'b1;
            svc_addr_o <= {vector_page_extension, link.vec_data};
          end
        endcase
      end
    end
  end

  assign global_mask_enable_o = global_mask_enable;
  assign saved_mask_enable_o  = saved_mask_enable;

endmodule

`default_nettype wire

// ---- core/citu_pkg.sv ----
// Shared constants and types of the interrupt and trap unit.
// Assumes one 10 MHz clock shared by the CPU side and the peripheral side.
`default_nettype none

package citu_pkg;

  // ---------------------------------------------------------------------
  // Internal I/O register map
  // ---------------------------------------------------------------------
  localparam logic [7:0]  LINE_ENABLE_OFS   = 8'h17;
  localparam logic [7:0]  VECTOR_BASE_OFS   = 8'h18;
  localparam logic [3:0]  LINE_ENABLE_RST   = 4'h0;
  localparam logic [6:0]  VECTOR_BASE_RST   = 7'h00;
  localparam int          VECTOR_BASE_LSB   = 1;   // Base bits sit in D7-D1
  localparam logic [7:0]  PAGE_RST          = 8'h00;
  localparam logic [15:0] EXTENSION_RST     = 16'h0000;

  // ---------------------------------------------------------------------
  // Fixed service addresses and timing
  // ---------------------------------------------------------------------
  localparam logic [31:0] NMI_ADDR          = 32'h0000_0066;
  localparam logic [31:0] RESTART_ADDR      = 32'h0000_0038;
  localparam int          NUM_LINES         = 4;
  localparam logic [2:0]  NMI_LOW_CYCLES    = 3'h4;  // Must outlast the 3-stage filter

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CITU_MODE_OPCODE  = 2'h0,
    CITU_MODE_RESTART = 2'h1,
    CITU_MODE_TABLE8  = 2'h2,
    CITU_MODE_VEC16   = 2'h3
  } citu_mode_e;

  typedef enum logic [2:0] {
    CITU_SVC_NMI      = 3'h0,
    CITU_SVC_OPCODE   = 3'h1,
    CITU_SVC_RESTART  = 3'h2,
    CITU_SVC_TABLE8   = 3'h3,
    CITU_SVC_VEC16    = 3'h4,
    CITU_SVC_ASSIGNED = 3'h5
  } citu_svc_e;

  typedef enum logic [1:0] {
    CITU_ST_IDLE   = 2'b00,
    CITU_ST_ACK    = 2'b01,
    CITU_ST_SAMPLE = 2'b11
  } citu_state_e;

endpackage

`default_nettype wire

// ---- core/citu_if.sv ----
// Pin bundle between the CPU interrupt unit and its peripherals.
// Assumes both ends sit on clk_i; the CPU end still filters the pins.
`default_nettype none

interface citu_if;
  logic        nmi_n;               // Nonmaskable request, falling edge counts
  logic [3:0]  maskable_request_n;  // Level requests, low active
  logic        ack;                 // Acknowledge transaction in progress
  logic [1:0]  ack_line;            // Line being acknowledged
  logic [15:0] vec_data;            // Vector from the acknowledged peripheral
  logic        vec_oe;              // Peripheral drives vec_data

  modport dev (
    input  nmi_n,
    input  maskable_request_n,
    output ack,
    output ack_line,
    input  vec_data,
    input  vec_oe
  );

  modport per (
    output nmi_n,
    output maskable_request_n,
    input  ack,
    input  ack_line,
    output vec_data,
    output vec_oe
  );
endinterface

`default_nettype wire

// ---- core/citu_sync.sv ----
// Three-stage input filter for pins from outside the clock domain.
// Assumes reset leaves every bit at the pins' idle level RST_VAL.
`default_nettype none

module citu_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // ---------------------------------------------------------------------
  // Shift chain; stage1 feeds stage2 only, to keep metastability contained
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else if (ce_i) begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once the two settled stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= RST_VAL;
    end else if (ce_i) begin
      level_o <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level_o);
    end
  end

endmodule

`default_nettype wire

// ---- core/citu_peripheral.sv ----
// Peripheral end: raises requests, holds them, drives the vector on a line 0 acknowledge.
// Assumes the CPU end on the same clock supplies ack and ack_line.
`default_nettype none

module citu_peripheral (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  citu_if.per              link,
  input  wire logic [3:0]  raise_i,
  input  wire logic        nmi_fire_i,
  input  wire logic [15:0] vector_i,
  output logic      [3:0]  pending_o,
  output logic             nmi_busy_o
);
  import citu_pkg::*;

  logic [2:0] nmi_cnt;

  // ---------------------------------------------------------------------
  // Request holders: a raise in the second acknowledge cycle is not lost
  // ---------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pending_o[i] <= 1'b0;
        end else if (ce_i) begin
          pending_o[i] <= raise_i[i]
                        | (pending_o[i] & ~(link.ack && link.ack_line == 2'(i)));
        end
      end
    end
  endgenerate

  assign link.maskable_request_n = ~pending_o;

  // ---------------------------------------------------------------------
  // Vector drive: registered, valid in the second acknowledge cycle
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.vec_data <= 16'h0000;
      link.vec_oe   <= 1'b0;
    end else if (ce_i) begin
      link.vec_oe <= link.ack && link.ack_line == 2'd0;
      if (link.ack && link.ack_line == 2'd0) begin
        link.vec_data <= vector_i;
      end
    end
  end

  // ---------------------------------------------------------------------
  // NMI pulse: held low long enough for the three-stage filter
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_cnt    <= 3'h0;
      link.nmi_n <= 1'b1;
    end else if (ce_i) begin
      if (nmi_fire_i && nmi_cnt == 3'h0) begin
        nmi_cnt    <= NMI_LOW_CYCLES;
        link.nmi_n <= 1'b0;
      end else if (nmi_cnt != 3'h0) begin
        nmi_cnt    <= nmi_cnt - 3'h1;
        link.nmi_n <= (nmi_cnt == 3'h1);
      end
    end
  end

  assign nmi_busy_o = (nmi_cnt != 3'h0);

endmodule

`default_nettype wire

// ---- bench/citu_chk.sv ----
// Link checker for the interrupt unit and its peripherals.
// Assumes the link signals as plain inputs, one clock, low reset.
`default_nettype none
module citu_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        nmi_n,
  input wire logic [3:0]  maskable_request_n,
  input wire logic        ack,
  input wire logic [1:0]  ack_line,
  input wire logic [15:0] vec_data,
  input wire logic        vec_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // Link properties
  // --------------------------------
  // Named acknowledges, so $past sees a plain signal
  logic ack0;
  logic ack3;
  assign ack0 = ack && ack_line == 2'h0;
  assign ack3 = ack && ack_line == 2'h3;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_two_cycles: assert property ($rose(ack) |=> ack ##1 !ack)
    else $error("ack length wrong");
  a_ack_line_steady: assert property (ack && $past(ack) |-> $stable(ack_line))
    else $error("ack_line moved during ack");
  a_ack_has_request: assert property ($rose(ack) |-> !maskable_request_n[ack_line])
    else $error("ack without a request");
  a_vec_drive_line0: assert property ($rose(ack) && !ack_line |=> vec_oe)
    else $error("no vector driven for line 0");
  a_vec_after_ack: assert property (vec_oe |-> ack || $past(ack))
    else $error("vector driven outside ack");
  a_vec_data_steady: assert property (vec_oe && $past(vec_oe) |-> $stable(vec_data))
    else $error("vector changed while driven");
  // Filter lag lets the pin rise up to three cycles after the ack
  a_req0_hold: assert property ($rose(maskable_request_n[0]) |->
    $past(ack0) || $past(ack0, 2) || $past(ack0, 3))
    else $error("line 0 released before ack");
  a_req3_hold: assert property ($rose(maskable_request_n[3]) |->
    $past(ack3) || $past(ack3, 2) || $past(ack3, 3))
    else $error("line 3 released before ack");
  a_nmi_pulse_width: assert property ($fell(nmi_n) |-> !nmi_n [*4] ##1 nmi_n)
    else $error("nmi pulse width wrong");
endmodule
`default_nettype wire

// ---- bench/tb_cpu_interrupt_trap_unit.sv ----
// Testbench: both ends of the interrupt unit joined by one link.
// Assumes a 10 MHz clock; inputs change 10 ns after each rising edge.
`default_nettype none
module tb_cpu_interrupt_trap_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import citu_pkg::*;
  // --------------------------------
  // Stimulus and instances
  // --------------------------------
  // One-cycle events: boundary, ei, di, im, return_from_nonmaskable, ld_pn, trap, page, ext, nmi
  localparam logic [13:0] E_BND = 14'h0001, E_EI = 14'h0002, E_DI = 14'h0004;
  localparam logic [13:0] E_IM = 14'h0008, E_RETURN_FROM_NONMASKABLE = 14'h0010, E_PN = 14'h0020;
  localparam logic [13:0] E_TRAP = 14'h0040, E_PG = 14'h0180, E_NMI = 14'h0200;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic [3:0]  sel = 4'h0;
  logic        dg = 1'b0;
  citu_mode_e  md = CITU_MODE_OPCODE;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_addr = 8'h00;
  logic [7:0]  io_wdata = 8'h00;
  logic [15:0] vec = 16'hC3A7;
  logic [7:0]  rdata, opc;
  logic        svc_valid, push, pn, glb, sav, busy;
  citu_svc_e   kind;
  logic [31:0] addr;
  int          n_errors = 0;
  int          checks = 0;
  citu_if lnk ();
  citu_device u_citu_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(lnk.dev),
    .boundary_i(ev[0]), .ei_i(ev[1]), .di_i(ev[2]), .di_global_i(dg), .line_sel_i(sel),
    .im_i(ev[3]), .im_mode_i(md), .return_from_nonmaskable_i(ev[4]), .ld_pn_i(ev[5]), .trap_i(ev[6]),
    .page_wr_i(ev[7]), .page_data_i(8'h5C), .ext_wr_i(ev[8]), .ext_data_i(16'h1234),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_rdata_o(rdata), .svc_valid_o(svc_valid), .svc_kind_o(kind), .svc_push_o(push),
    .svc_addr_o(addr), .svc_opcode_o(opc), .parity_overflow_flag_o(pn),
    .global_mask_enable_o(glb), .saved_mask_enable_o(sav), .busy_o(busy));
  citu_peripheral u_citu_peripheral (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .link(lnk.per), .raise_i(ev[13:10]), .nmi_fire_i(ev[9]), .vector_i(vec),
    .pending_o(), .nmi_busy_o());
  citu_chk u_citu_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .nmi_n(lnk.nmi_n),
    .maskable_request_n(lnk.maskable_request_n), .ack(lnk.ack), .ack_line(lnk.ack_line),
    .vec_data(lnk.vec_data), .vec_oe(lnk.vec_oe));
  // Free-running 100 ns clock
  initial forever #50 clk_i = ~clk_i;
  // Clearing here, not in fire, keeps back-to-back events to one assignment
  task automatic step(input int n);
    ev = 14'h0000;
    repeat (n) @(posedge clk_i);
    #10;
  endtask
  // The event stands for one edge; the next step or fire replaces it
  task automatic fire(input logic [13:0] e);
    ev = e;
    @(posedge clk_i);
    #10;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    io_addr = a;
    io_rd = 1'b1;
    step(1);
    io_rd = 1'b0;
    step(1);
    chk(rdata, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    step(1);
    io_wr = 1'b0;
  endtask
  // Bounded wait for a service pulse; a miss ends the run
  task automatic wsvc();
    int i;
    for (i = 0; i < 20 && svc_valid !== 1'b1; i++) step(1);
    if (i == 20) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic t_regs();
    chk({glb, sav, pn}, 3'h0);
    rd(LINE_ENABLE_OFS, 8'h00);
    rd(VECTOR_BASE_OFS, 8'h00);
    wr(LINE_ENABLE_OFS, 8'hFF);
    rd(LINE_ENABLE_OFS, 8'h0F);
    wr(VECTOR_BASE_OFS, 8'hA5);
    rd(VECTOR_BASE_OFS, 8'hA4);
    rd(8'h33, 8'h00);
    fire(E_PG);
    $display("test regs done");
  endtask
  task automatic t_nmi();
    fire(E_EI);
    fire(E_BND);
    fire(E_NMI);
    step(8);
    fire(E_BND);
    wsvc();
    chk({kind, push, addr}, {CITU_SVC_NMI, 1'b1, NMI_ADDR});
    chk({glb, sav}, 2'b01);
    fire(E_PN);
    chk(pn, 1'b1);
    fire(E_RETURN_FROM_NONMASKABLE);
    chk({glb, sav}, 2'b11);
    fire(E_TRAP);
    chk({glb, sav}, 2'b00);
    $display("test nmi done");
  endtask
  task automatic t_lines();
    dg = 1'b1;
    sel = 4'h5;
    fire(E_EI);
    fire(E_DI);
    chk({glb, sav}, 2'b00);
    rd(LINE_ENABLE_OFS, 8'h0A);
    fire({4'hB, 10'h000});
    step(6);
    fire(E_BND);
    chk({lnk.ack, busy}, 2'h0);
    sel = 4'h0;
    fire(E_EI);
    fire(E_BND);
    fire(E_BND);
    wsvc();
    chk({kind, push, addr}, {CITU_SVC_ASSIGNED, 1'b1, 16'h1234, 7'h52, 7'h01, 2'h0});
    chk({glb, sav}, 2'b00);
    step(6);
    fire(E_EI);
    fire(E_BND);
    fire(E_BND);
    wsvc();
    chk(addr, {16'h1234, 7'h52, 7'h03, 2'h0});
    $display("test lines done");
  endtask
  // Line 0 in every mode; ei shadow and boundary-only acceptance on the way
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      md = citu_mode_e'(m);
      fire(E_IM);
      fire({4'h1, 10'h000});
      step(6);
      sel = 4'h1;
      fire(E_EI);
      fire(E_BND);
      chk(lnk.ack, 1'b0);
      step(3);
      chk({lnk.ack, busy}, 2'h0);
      fire(E_BND);
      wsvc();
      case (m)
        0: chk({kind, push, opc}, {CITU_SVC_OPCODE, 1'b0, vec[15:8]});
        1: chk({kind, push, addr}, {CITU_SVC_RESTART, 1'b1, RESTART_ADDR});
        2: chk({kind, push, addr}, {CITU_SVC_TABLE8, 1'b1, 24'h12345C, vec[15:9], 1'b0});
        default: chk({kind, push, addr}, {CITU_SVC_VEC16, 1'b1, 16'h1234, vec});
      endcase
      chk({glb, sav}, 2'b00);
      step(6);
    end
    $display("test modes done");
  endtask
  task automatic conclude();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset held for 20 cycles, then the scenarios in turn
  initial begin
    step(20);
    rst_n_i = 1'b1;
    step(2);
    t_regs();
    t_nmi();
    t_lines();
    t_modes();
    conclude();
  end
endmodule
`default_nettype wire
